//--- shared/mmdbg_pkg.sv
package mmdbg_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] MMDBG_OFS_CTL = 8'h48;
  localparam logic [7:0] MMDBG_OFS_SEL = 8'hfc;
  localparam int MMDBG_MDC_BIT  = 16;
  localparam int MMDBG_DIR_BIT  = 18;
  localparam int MMDBG_DATA_BIT = 19;
  localparam int MMDBG_SEL_W    = 3;
  localparam logic [2:0] MMDBG_SEL_RST = 3'h0;
  // ----------------------------------------------------------------
  // Debug observation modes
  // ----------------------------------------------------------------
  localparam logic [2:0] MMDBG_MAC_EXT_PHY = 3'h4;
  localparam logic [2:0] MMDBG_PHY_OBSERVE = 3'h6;
  localparam logic [2:0] MMDBG_PHY_ALONE   = 3'h1;
  // ----------------------------------------------------------------
  // Bus answers and widths
  // ----------------------------------------------------------------
  localparam logic [1:0] MMDBG_RESP_OKAY   = 2'h0;
  localparam logic [1:0] MMDBG_RESP_SLVERR = 2'h2;
  localparam int MMDBG_AW    = 8;
  localparam int MMDBG_BRA_W = 17;
  localparam int MMDBG_BRD_W = 8;
  typedef enum logic [1:0] {
    MMDBG_DEC_NONE = 2'h1,
    MMDBG_DEC_CTL  = 2'h2
  } mmdbg_dec_t;
endpackage

//--- hw/mmdbg_top.sv
`timescale 1ns/1ns
`default_nettype none
module mmdbg_top
  import mmdbg_pkg::*;
(
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  input  wire logic [MMDBG_AW-1:0]    s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [MMDBG_AW-1:0]    s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  output logic                        mgmt_mdc,
  input  wire logic                   mgmt_mdio_i,
  output logic                        mgmt_mdio_o,
  output logic                        mgmt_mdio_oe,
  input  wire logic                   obs_clk,
  input  wire logic [3:0]             mii_rxd,
  input  wire logic                   mii_rx_dv,
  input  wire logic                   mii_rx_er,
  input  wire logic                   mii_rx_clk,
  input  wire logic                   mii_crs,
  input  wire logic                   mii_col,
  input  wire logic [3:0]             mii_txd,
  input  wire logic                   mii_tx_en,
  input  wire logic                   mii_tx_er,
  input  wire logic                   mii_tx_clk,
  output logic [MMDBG_BRA_W-1:0]      rom_addr,
  output logic [MMDBG_BRD_W-1:0]      rom_data,
  output logic                        rom_oe_n,
  output logic                        rom_we_n
);

  function automatic mmdbg_dec_t dec(input logic [MMDBG_AW-1:0] a);
    if (a == MMDBG_OFS_CTL) begin
      return MMDBG_DEC_CTL;
    end
    return MMDBG_DEC_NONE;
  endfunction

  // ----------------------------------------------------------------
  // Bus write channel
  // ----------------------------------------------------------------
  logic [MMDBG_AW-1:0] aw_addr;
  logic                aw_held;
  logic [31:0]         w_data;
  logic [3:0]          w_strb;
  logic                w_held;
  logic                wr_do;
  logic                ctl_mdc;
  logic                ctl_dir;
  logic                ctl_data;
  logic [2:0]          sel;
  logic                mdi_s1;
  logic                mdi_s2;
  logic                sel_tgl;

  assign wr_do = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      aw_held       <= 1'b0;
      aw_addr       <= '0;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_do) begin
        aw_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      w_held       <= 1'b0;
      w_data       <= '0;
      w_strb       <= '0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_do) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= MMDBG_RESP_OKAY;
    end else if (wr_do) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (dec(aw_addr) == MMDBG_DEC_CTL || aw_addr == MMDBG_OFS_SEL) ?
                      MMDBG_RESP_OKAY : MMDBG_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Management control bits
  // ----------------------------------------------------------------
  // pins change only on a software write.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctl_mdc  <= 1'b0;
      ctl_dir  <= 1'b1;
      ctl_data <= 1'b0;
    end else if (wr_do && dec(aw_addr) == MMDBG_DEC_CTL && w_strb[2]) begin
      ctl_mdc  <= w_data[MMDBG_MDC_BIT];
      ctl_dir  <= w_data[MMDBG_DIR_BIT];
      ctl_data <= w_data[MMDBG_DATA_BIT];
    end
  end

  // Each selector write with strobe bit 0 set flips a toggle that tells the observation side to take the new word.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sel     <= MMDBG_SEL_RST;
      sel_tgl <= 1'b0;
    end else if (wr_do && aw_addr == MMDBG_OFS_SEL && w_strb[0]) begin
      sel     <= w_data[MMDBG_SEL_W-1:0];
      sel_tgl <= !sel_tgl;
    end
  end

  // direction bit one turns the data pin around to input.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mgmt_mdc     <= 1'b0;
      mgmt_mdio_o  <= 1'b0;
      mgmt_mdio_oe <= 1'b0;
    end else begin
      mgmt_mdc     <= ctl_mdc;
      mgmt_mdio_o  <= ctl_data;
      mgmt_mdio_oe <= !ctl_dir;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mdi_s1 <= 1'b0;
      mdi_s2 <= 1'b0;
    end else begin
      mdi_s1 <= mgmt_mdio_i;
      mdi_s2 <= mdi_s1;
    end
  end

  // ----------------------------------------------------------------
  // Bus read channel
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= MMDBG_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= '0;
        s_axi_rresp  <= MMDBG_RESP_OKAY;
        if (dec(s_axi_araddr) == MMDBG_DEC_CTL) begin
          s_axi_rdata[MMDBG_MDC_BIT] <= ctl_mdc;
          s_axi_rdata[MMDBG_DIR_BIT] <= ctl_dir;
          s_axi_rdata[MMDBG_DATA_BIT] <= ctl_dir ? mdi_s2 : ctl_data;
        end else if (s_axi_araddr == MMDBG_OFS_SEL) begin
          s_axi_rdata[MMDBG_SEL_W-1:0] <= sel;
        end else begin
          s_axi_rresp <= MMDBG_RESP_SLVERR;
        end
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Observation domain
  // ----------------------------------------------------------------
  localparam int NSIG = 20;
  logic [NSIG-1:0] raw;
  logic [NSIG-1:0] s1;
  logic [NSIG-1:0] s;
  logic [1:0]      rs;
  logic            orst;
  logic [3:0]      rxd;
  logic [3:0]      txd;
  logic            rx_dv, rx_er, rx_clk, crs, col, tx_en, tx_er, tx_clk;
  logic            o_mdc, o_mdo, o_mdi, o_oe;
  logic [2:0]      osel;
  logic [2:0]      sel_sync;
  logic            mdio_v;

  assign raw = {mii_rxd, mii_rx_dv, mii_rx_er, mii_rx_clk, mii_crs, mii_col,
                mii_txd, mii_tx_en, mii_tx_er, mii_tx_clk,
                mgmt_mdc, mgmt_mdio_o, mdi_s2, mgmt_mdio_oe};
  assign {rxd, rx_dv, rx_er, rx_clk, crs, col, txd, tx_en, tx_er, tx_clk,
          o_mdc, o_mdo, o_mdi, o_oe} = s;
  assign mdio_v = o_oe ? o_mdo : o_mdi;

  always_ff @(posedge obs_clk) begin
    rs   <= {rs[0], rst};
    orst <= rs[1];
  end

  always_ff @(posedge obs_clk) begin
    if (orst) begin
      s1 <= '0;
      s  <= '0;
    end else begin
      s1 <= raw;
      s  <= s1;
    end
  end

  // The selector word is taken only after its toggle has passed two flops, so it has
  // stood still for a whole observation period and no mixed value can be seen.
  always_ff @(posedge obs_clk) begin
    if (orst) begin
      sel_sync <= '0;
      osel     <= MMDBG_SEL_RST;
    end else begin
      sel_sync <= {sel_sync[1:0], sel_tgl};
      if (sel_sync[2] != sel_sync[1]) begin
        osel <= sel;
      end
    end
  end

  always_ff @(posedge obs_clk) begin
    if (orst) begin
      rom_addr <= '0;
      rom_data <= '0;
      rom_oe_n <= 1'b1;
      rom_we_n <= 1'b1;
    end else begin
      rom_addr <= '0;
      rom_data <= '0;
      rom_oe_n <= 1'b1;
      rom_we_n <= 1'b1;
      case (osel)
        MMDBG_MAC_EXT_PHY: begin
          rom_addr[11:0] <= {o_mdc, tx_en, txd, tx_er, 1'b0, mdio_v, crs, col, rx_er};
          rom_data[4:0]  <= {rx_dv, rxd};
          rom_oe_n       <= rx_clk;
          rom_we_n       <= rx_clk;
        end
        MMDBG_PHY_OBSERVE: begin
          rom_addr      <= {rxd, crs, col, rx_clk, rx_dv, rx_er, rx_clk,
                            txd, tx_er, tx_en, o_mdi};
          rom_data[7:6] <= {o_mdo, o_mdc};
        end
        MMDBG_PHY_ALONE: begin
          rom_addr[16:9] <= {rxd, crs, col, rx_er, rx_dv};
          rom_data       <= {o_mdc, mdio_v, tx_er, tx_en, txd};
          rom_oe_n       <= rx_clk;
          rom_we_n       <= tx_clk;
        end
        default: begin
          rom_oe_n <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_mdc_from_write: assert property (@(posedge ref_clk) disable iff (rst)
    wr_do && dec(aw_addr) == MMDBG_DEC_CTL && w_strb[2]
      |=> ##1 mgmt_mdc == $past(w_data[MMDBG_MDC_BIT], 2))
    else $error("mdc does not follow written bit");
  a_mdc_held_idle: assert property (@(posedge ref_clk) disable iff (rst)
    !wr_do [*2] |=> $stable(mgmt_mdc) && $stable(mgmt_mdio_o))
    else $error("management pins changed without a write");
  a_dir_drives_oe: assert property (@(posedge ref_clk) disable iff (rst)
    wr_do && dec(aw_addr) == MMDBG_DEC_CTL && w_strb[2]
      |=> ##1 mgmt_mdio_oe == !$past(w_data[MMDBG_DIR_BIT], 2))
    else $error("direction bit polarity wrong");
  a_mdio_out_data: assert property (@(posedge ref_clk) disable iff (rst)
    mgmt_mdio_oe |-> mgmt_mdio_o == $past(ctl_data))
    else $error("mdio output differs from data bit");
  a_mdio_read_live: assert property (@(posedge ref_clk) disable iff (rst)
    s_axi_arvalid && s_axi_arready && dec(s_axi_araddr) == MMDBG_DEC_CTL && ctl_dir
      |=> s_axi_rdata[MMDBG_DATA_BIT] == $past(mdi_s2))
    else $error("read of data bit not the pin level");
  a_bresp_after_pair: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(s_axi_bvalid) |-> $past(aw_held && w_held))
    else $error("write answered before address and data");
  a_rvalid_held: assert property (@(posedge ref_clk) disable iff (rst)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped before rready");
  a_unmapped_err: assert property (@(posedge ref_clk) disable iff (rst)
    s_axi_arvalid && s_axi_arready && dec(s_axi_araddr) == MMDBG_DEC_NONE
      && s_axi_araddr != MMDBG_OFS_SEL |=> s_axi_rresp == MMDBG_RESP_SLVERR)
    else $error("unmapped read not refused");
  a_phy_alone_map: assert property (@(posedge obs_clk) disable iff (orst)
    osel == MMDBG_PHY_ALONE |=> rom_we_n == $past(tx_clk) && rom_oe_n == $past(rx_clk))
    else $error("standalone strobes wrong");
  a_phy_obs_map: assert property (@(posedge obs_clk) disable iff (orst)
    osel == MMDBG_PHY_OBSERVE |=> rom_data[7:6] == $past({o_mdo, o_mdc}))
    else $error("monitor data pins wrong");
  a_mac_ext_map: assert property (@(posedge obs_clk) disable iff (orst)
    osel == MMDBG_MAC_EXT_PHY |=> rom_addr[11] == $past(o_mdc) && rom_oe_n == $past(rx_clk))
    else $error("mac side mapping wrong");

  c_ctl_write: cover property (@(posedge ref_clk) wr_do && dec(aw_addr) == MMDBG_DEC_CTL);
  c_ctl_read: cover property (@(posedge ref_clk)
    s_axi_rvalid && s_axi_rready && s_axi_rdata[MMDBG_DIR_BIT]);
  c_mode_alone: cover property (@(posedge obs_clk) osel == MMDBG_PHY_ALONE);
  c_mode_obs: cover property (@(posedge obs_clk) osel == MMDBG_PHY_OBSERVE);

endmodule
`default_nettype wire

//--- testbench/mmdbg_phy_model.sv
`timescale 1ns/1ns
`default_nettype none
module mmdbg_phy_model #(
  parameter logic [7:0] PAT = 8'hb4
) (
  input  wire logic mdc,
  input  wire logic mdio_o,
  input  wire logic mdio_oe,
  output logic      mdio_i,
  output logic      obs_clk
);
  logic [7:0] sh = PAT;
  initial obs_clk = 1'b0;
  always begin
    #62 obs_clk = 1'b1;
    #63 obs_clk = 1'b0;
  end
  always @(posedge mdc) begin
    if (!mdio_oe) begin
      sh <= {sh[6:0], 1'b1};
    end
  end
  assign mdio_i = mdio_oe ? mdio_o : sh[7];
endmodule
`default_nettype wire

//--- testbench/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import mmdbg_pkg::*;
  typedef struct {logic [31:0] w; logic [2:0] p; logic [31:0] rb;} mmdbg_row_t;
  localparam logic [7:0] PHY_PAT = 8'hb4;
  logic        ref_clk = 1'b0, rst = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'h0, mii_rxd, mii_txd;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        mgmt_mdc, mgmt_mdio_i, mgmt_mdio_o, mgmt_mdio_oe, obs_clk;
  logic        mii_rx_dv, mii_rx_er, mii_rx_clk, mii_crs, mii_col;
  logic        mii_tx_en, mii_tx_er, mii_tx_clk, rom_oe_n, rom_we_n;
  logic [15:0] mii = 16'h0;
  logic [16:0] rom_addr;
  logic [7:0]  rom_data;
  int          n_fail = 0, tests_run = 0;
  mmdbg_row_t  rows [4] = '{'{32'h0001_0000, 3'b110, 32'h0001_0000},
    '{32'h0008_0000, 3'b011, 32'h0008_0000}, '{32'hfff9_ffff, 3'b111, 32'h0009_0000},
    '{32'h000c_0000, 3'b001, 32'h000c_0000}};
  logic [2:0]  modes [4] = '{MMDBG_PHY_ALONE, MMDBG_MAC_EXT_PHY, MMDBG_PHY_OBSERVE, 3'h2};
  assign {mii_rxd, mii_rx_dv, mii_rx_er, mii_rx_clk, mii_crs, mii_col, mii_txd, mii_tx_en,
          mii_tx_er, mii_tx_clk} = mii;
  always #5 ref_clk = ~ref_clk;
  mmdbg_top uut (.ref_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mgmt_mdc, .mgmt_mdio_i, .mgmt_mdio_o,
    .mgmt_mdio_oe, .obs_clk, .mii_rxd, .mii_rx_dv, .mii_rx_er, .mii_rx_clk, .mii_crs,
    .mii_col, .mii_txd, .mii_tx_en, .mii_tx_er, .mii_tx_clk, .rom_addr, .rom_data,
    .rom_oe_n, .rom_we_n);
  mmdbg_phy_model #(.PAT(PHY_PAT)) phy (.mdc(mgmt_mdc), .mdio_o(mgmt_mdio_o),
    .mdio_oe(mgmt_mdio_oe), .mdio_i(mgmt_mdio_i), .obs_clk);
  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic hang(input string n);
    n_fail++;
    $display("mismatch %s expected answer seen none", n);
    report_and_stop();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    int i;
    logic ga, gw;
    ga = 1'b0;
    gw = 1'b0;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 60 && !(s_axi_bvalid && ga && gw); i++) begin
      @(posedge ref_clk);
      if (s_axi_awready) begin
        ga = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready) begin
        gw = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    if (i == 60) hang("bvalid");
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er,
                    input string n);
    int i;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 60 && !s_axi_rvalid; i++) begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    if (i == 60) hang("rvalid");
    s_axi_rready <= 1'b0;
    chk(n, e, s_axi_rdata);
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
  endtask
  task automatic pins(input logic [2:0] e);
    chk("mdc oe mdio", {29'h0, e}, {29'h0, mgmt_mdc, mgmt_mdio_oe, mgmt_mdio_o});
  endtask
  task automatic rom(input logic [26:0] e, input logic [26:0] m);
    int i;
    for (i = 0; i < 100 && ((({rom_addr, rom_data, rom_oe_n, rom_we_n} ^ e) & m) != 0); i++)
      @(posedge ref_clk);
    chk("rom pins", {5'h0, e & m}, {5'h0, {rom_addr, rom_data, rom_oe_n, rom_we_n} & m});
  endtask
  // Expected debug pins with mdc, mdio in and mdio out all high.
  function automatic logic [53:0] exp_rom(input logic [2:0] s, input logic [15:0] v);
    case (s)
      3'h1: return {v[15:12], v[8], v[7], v[10], v[11], 9'h0, 2'b11, v[1], v[2], v[6:3],
                    v[9], v[0], 27'h7f803ff};
      3'h4: return {5'h0, 1'b1, v[2], v[6:3], v[1], 1'b0, 1'b1, v[8], v[7], v[10], 3'h0,
                    v[11], v[15:12], v[9], v[9], 27'h03ffc7f};
      3'h6: return {v[15:12], v[8], v[7], v[9], v[11], v[10], v[9], v[6:3], v[1], v[2],
                    1'b1, 8'hc0, 2'b11, 27'h7ffffff};
      default: return {25'h0, 2'b11, 27'h7ffffff};
    endcase
  endfunction
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [26:0] e, m;
    repeat (8) @(posedge obs_clk);
    @(posedge ref_clk);
    rst <= 1'b0;
    pins(3'b000);
    rom(27'h3, 27'h7ffffff);
    rd(MMDBG_OFS_CTL, {12'h0, PHY_PAT[7], 19'h40000}, MMDBG_RESP_OKAY, "ctl reset");
    rd(MMDBG_OFS_SEL, 32'h0, MMDBG_RESP_OKAY, "sel reset");
    for (int k = 0; k < 8; k++) begin
      rd(MMDBG_OFS_CTL, {12'h0, PHY_PAT[7-k], 19'h40000}, MMDBG_RESP_OKAY, "mdio in");
      wr(MMDBG_OFS_CTL, 32'h0005_0000, 4'h4, MMDBG_RESP_OKAY);
      repeat (2) @(posedge ref_clk);
      pins(3'b100);
      wr(MMDBG_OFS_CTL, 32'h0004_0000, 4'h4, MMDBG_RESP_OKAY);
      repeat (4) @(posedge ref_clk);
    end
    for (int r = 0; r < 4; r++) begin
      wr(MMDBG_OFS_CTL, rows[r].w, 4'hf, MMDBG_RESP_OKAY);
      repeat (2) @(posedge ref_clk);
      pins(rows[r].p);
      repeat (20) @(posedge ref_clk);
      pins(rows[r].p);
      rd(MMDBG_OFS_CTL, rows[r].rb, MMDBG_RESP_OKAY, "ctl readback");
    end
    wr(MMDBG_OFS_CTL, 32'h0, 4'hb, MMDBG_RESP_OKAY);
    repeat (2) @(posedge ref_clk);
    pins(3'b001);
    wr(8'h40, 32'hffff_ffff, 4'hf, MMDBG_RESP_SLVERR);
    rd(8'h40, 32'h0, MMDBG_RESP_SLVERR, "unmapped");
    wr(MMDBG_OFS_CTL, 32'h0009_0000, 4'hf, MMDBG_RESP_OKAY);
    for (int j = 0; j < 8; j++) begin
      wr(MMDBG_OFS_SEL, {29'h0, modes[j%4]}, 4'h1, MMDBG_RESP_OKAY);
      mii <= (j < 4) ? 16'ha5c3 : 16'h5a3c;
      {e, m} = exp_rom(modes[j%4], (j < 4) ? 16'ha5c3 : 16'h5a3c);
      rom(e, m);
    end
    rd(MMDBG_OFS_SEL, 32'h2, MMDBG_RESP_OKAY, "sel readback");
    wr(MMDBG_OFS_SEL, 32'h6, 4'he, MMDBG_RESP_OKAY);
    repeat (60) @(posedge ref_clk);
    rom(27'h3, 27'h7ffffff);
    wr(MMDBG_OFS_SEL, {29'h0, MMDBG_MAC_EXT_PHY}, 4'h1, MMDBG_RESP_OKAY);
    {e, m} = exp_rom(MMDBG_MAC_EXT_PHY, 16'h5a3c);
    rom(e, m);
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (8) @(posedge obs_clk);
    @(posedge ref_clk);
    rst <= 1'b0;
    pins(3'b000);
    repeat (60) @(posedge ref_clk);
    rom(27'h3, 27'h7ffffff);
    rd(MMDBG_OFS_SEL, 32'h0, MMDBG_RESP_OKAY, "sel after reset");
    rd(MMDBG_OFS_CTL, 32'h000c_0000, MMDBG_RESP_OKAY, "ctl after reset");
    report_and_stop();
  end
endmodule
`default_nettype wire
